// [hdl/vmps_pkg.sv]
// Constants for the vector mask, first-element, program counter and status register block.
// Assumes a single clock and a plain register port driven by the execution pipeline and software.
package vmps_pkg;

  localparam int ELEMS      = 128;
  localparam int IDX_W      = 7;
  localparam int LEN_W      = 8;
  localparam int ADDR_W     = 4;

  // Register indexes on the software port, one 32-bit word each.
  localparam logic [3:0] REG_PC    = 4'h0;
  localparam logic [3:0] REG_PSW   = 4'h1;
  localparam logic [3:0] REG_FIRST = 4'h2;
  localparam logic [3:0] REG_LEN   = 4'h3;
  localparam logic [3:0] REG_MASK0 = 4'h4;
  localparam logic [3:0] REG_MASK1 = 4'h5;
  localparam logic [3:0] REG_MASK2 = 4'h6;
  localparam logic [3:0] REG_MASK3 = 4'h7;
  localparam logic [3:0] REG_STAT  = 4'h8;

  // Status word field positions.
  localparam int B_ACARRY  = 31;
  localparam int B_AOVF    = 30;
  localparam int B_ADZ     = 29;
  localparam int B_IVE     = 28;
  localparam int B_TRACE   = 27;
  localparam int B_FRM_HI  = 26;
  localparam int B_FRM_LO  = 25;
  localparam int B_SERIAL  = 24;
  localparam int B_SCARRY  = 23;
  localparam int B_SOVF    = 22;
  localparam int B_SDZ     = 21;
  localparam int B_DZE     = 20;
  localparam logic [31:0] PSW_IMPL_MASK = 32'hfff00000;

  // Reset values and the largest length.
  localparam logic [31:0] PC_RST    = 32'h00000000;
  localparam logic [31:0] PSW_RST   = 32'h00000000;
  localparam logic [IDX_W-1:0] FIRST_RST = 7'h00;
  localparam logic [LEN_W-1:0] LEN_RST   = 8'h00;
  localparam logic [LEN_W-1:0] LEN_MAX   = 8'h80;

  // Frame kinds.
  typedef enum logic [1:0]
  {
    FRM_CTX   = 2'b00,
    FRM_EXT   = 2'b01,
    FRM_LONG  = 2'b10,
    FRM_SHORT = 2'b11
  } vmps_frame_e;

  // Issue sequencer states.
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_BUSY  = 2'b01,
    ST_TRAP  = 2'b11
  } vmps_state_e;

endpackage : vmps_pkg

// [hdl/vmps_exec_if.sv]
// Interface carrying pipeline event signals from the top to the status word module.
// Assumes all signals are synchronous to the single block clock.
`timescale 1ns/1ns
`default_nettype none
interface vmps_exec_if;
  logic        a_carry_vld;
  logic        a_carry;
  logic        a_ovf;
  logic        a_dz;
  logic        s_carry_vld;
  logic        s_carry;
  logic        s_ovf;
  logic        s_dz;
  logic        frame_vld;
  logic [1:0]  frame_kind;
  logic        sw_wr;
  logic [31:0] sw_data;
  logic [31:0] processor_status_word;

  // The top drives events; the status module keeps the word.
  modport src
  (
    output a_carry_vld, a_carry, a_ovf, a_dz, s_carry_vld, s_carry, s_ovf, s_dz,
    output frame_vld, frame_kind, sw_wr, sw_data,
    input  processor_status_word
  );
  modport dst
  (
    input  a_carry_vld, a_carry, a_ovf, a_dz, s_carry_vld, s_carry, s_ovf, s_dz,
    input  frame_vld, frame_kind, sw_wr, sw_data,
    output processor_status_word
  );
endinterface : vmps_exec_if
`default_nettype wire

// [hdl/vmps_status_word.sv]
// Status word register with sticky flags and carry capture.
// Assumes hardware events and software writes arrive through the exec interface.
`timescale 1ns/1ns
`default_nettype none
module vmps_status_word
  import vmps_pkg::*;
(
  input wire logic  clk,
  input wire logic  srst,
  vmps_exec_if.dst  ev
);

  logic [31:0] psw_r;
  logic [31:0] psw_nxt;

  assign ev.processor_status_word = psw_r;

  // Software write goes first so that hardware events in the same cycle win.
  always_comb
  begin
    psw_nxt = psw_r;
    if (ev.sw_wr)
      psw_nxt = ev.sw_data & PSW_IMPL_MASK;
    if (ev.a_carry_vld)
      psw_nxt[B_ACARRY] = ev.a_carry;
    if (ev.s_carry_vld)
      psw_nxt[B_SCARRY] = ev.s_carry;
    if (ev.a_ovf)
      psw_nxt[B_AOVF] = 1'b1;
    if (ev.a_dz)
      psw_nxt[B_ADZ] = 1'b1;
    if (ev.s_ovf)
      psw_nxt[B_SOVF] = 1'b1;
    if (ev.s_dz)
      psw_nxt[B_SDZ] = 1'b1;
    if (ev.frame_vld)
      psw_nxt[B_FRM_HI:B_FRM_LO] = ev.frame_kind;
  end

  // The word itself.
  always_ff @(posedge clk)
  begin
    if (srst)
      psw_r <= PSW_RST;
    else
      psw_r <= psw_nxt;
  end

endmodule : vmps_status_word
`default_nettype wire

// [hdl/vmps_index_unit.sv]
// Effective length and element index arithmetic for the first-element offset.
// Assumes length is already clamped to 0..128 and offset is 0..127.
`timescale 1ns/1ns
`default_nettype none
module vmps_index_unit
  import vmps_pkg::*;
(
  input  wire logic [IDX_W-1:0] first,
  input  wire logic [LEN_W-1:0] len,
  input  wire logic             use_first,
  input  wire logic [IDX_W-1:0] scalar_idx,
  output logic      [LEN_W-1:0] eff_len,
  output logic      [IDX_W-1:0] elem_idx
);

  logic [LEN_W:0] sum;
  logic [LEN_W-1:0] room;

  // Length limited to the room left after the offset.
  always_comb
  begin
    sum  = {2'b00, first} + {1'b0, len};
    room = LEN_MAX - {1'b0, first};
    if (use_first && (sum > {1'b0, LEN_MAX}))
      eff_len = room;
    else
      eff_len = len;
  end

  // Seven-bit sum wraps naturally, which is the modulo 128 index.
  assign elem_idx = first + scalar_idx;

endmodule : vmps_index_unit
`default_nettype wire

// [hdl/vmps_regs.sv]
// Top of the vector mask, offset, program counter and status word block.
// Assumes the pipeline drives one-cycle event strobes and software uses the plain register port.
`timescale 1ns/1ns
`default_nettype none
module vmps_regs
  import vmps_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  // Software register port.
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Vector compare writes the mask.
  input  wire logic              cmp_vld,
  input  wire logic [ELEMS-1:0]  cmp_result,
  output logic      [ELEMS-1:0]  elem_mask,
  // Length load from the pipeline.
  input  wire logic              len_load,
  input  wire logic [31:0]       len_value,
  // Operand indexing.
  input  wire logic [4:0]        opnd_select,
  input  wire logic              opnd_is_mask,
  input  wire logic [IDX_W-1:0]  scalar_idx,
  output logic      [LEN_W-1:0]  eff_len,
  output logic      [IDX_W-1:0]  elem_idx,
  output logic                   vec_suppress,
  // Status events.
  input  wire logic              a_carry_vld,
  input  wire logic              a_carry,
  input  wire logic              a_ovf,
  input  wire logic              a_dz,
  input  wire logic              s_carry_vld,
  input  wire logic              s_carry,
  input  wire logic              s_ovf,
  input  wire logic              s_dz,
  input  wire logic              frame_vld,
  input  wire logic [1:0]        frame_kind,
  // Instruction flow.
  input  wire logic              issue_req,
  input  wire logic              instr_done,
  input  wire logic              trap_ack,
  input  wire logic              pc_load,
  input  wire logic [31:0]       pc_value,
  output logic                   issue_ok,
  output logic      [31:0]       fetch_addr,
  output logic                   int_trap,
  output logic                   dz_trap,
  output logic                   trace_trap,
  output logic                   serial_mode,
  output logic      [31:0]       status_word
);

  vmps_exec_if ev ();

  logic [ELEMS-1:0]  mask_r;
  logic [IDX_W-1:0]  first_r;
  logic [LEN_W-1:0]  len_r;
  logic [31:0]       pc_r;
  logic [31:0]       pc_nxt;
  logic [31:0]       rdata_r;
  logic [31:0]       processor_status_word;
  logic              advance;
  logic              trace_pend_r;
  logic              busy_r;
  vmps_state_e       state_r;

  // Decoding shared by the status word, offset and length writes.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction : hit

  // Clamp a signed length load into 0..128.
  function automatic logic [LEN_W-1:0] clamp_len(input logic [31:0] v);
    if (v[31])
      clamp_len = LEN_RST;
    else if (v > 32'(LEN_MAX))
      clamp_len = LEN_MAX;
    else
      clamp_len = v[LEN_W-1:0];
  endfunction : clamp_len

  // Events into the status word module.
  assign ev.a_carry_vld = a_carry_vld;
  assign ev.a_carry     = a_carry;
  assign ev.a_ovf       = a_ovf;
  assign ev.a_dz        = a_dz;
  assign ev.s_carry_vld = s_carry_vld;
  assign ev.s_carry     = s_carry;
  assign ev.s_ovf       = s_ovf;
  assign ev.s_dz        = s_dz;
  assign ev.frame_vld   = frame_vld;
  assign ev.frame_kind  = frame_kind;
  assign ev.sw_wr       = reg_wr && hit(reg_addr, REG_PSW);
  assign ev.sw_data     = reg_wdata;
  assign processor_status_word            = ev.processor_status_word;

  vmps_status_word u_psw
  (
    .clk  (clk),
    .srst (srst),
    .ev   (ev.dst)
  );

  // Mask: a compare overwrites every bit; software writes one 32-bit quarter.
  always_ff @(posedge clk)
  begin
    if (srst)
      mask_r <= '0;
    else if (cmp_vld)
      mask_r <= cmp_result;
    else if (reg_wr && (reg_addr[3:2] == 2'b01))
    begin
      case (reg_addr[1:0])
        2'b00: mask_r[31:0]   <= reg_wdata;
        2'b01: mask_r[63:32]  <= reg_wdata;
        2'b10: mask_r[95:64]  <= reg_wdata;
        default: mask_r[127:96] <= reg_wdata;
      endcase
    end
  end

  assign elem_mask = mask_r;

  // First-element offset, seven bits so 127 is the largest value.
  always_ff @(posedge clk)
  begin
    if (srst)
      first_r <= FIRST_RST;
    else if (reg_wr && hit(reg_addr, REG_FIRST))
      first_r <= reg_wdata[IDX_W-1:0];
  end

  // Element count; the pipeline load wins over a software write in the same cycle.
  always_ff @(posedge clk)
  begin
    if (srst)
      len_r <= LEN_RST;
    else if (len_load)
      len_r <= clamp_len(len_value);
    else if (reg_wr && hit(reg_addr, REG_LEN))
      len_r <= clamp_len(reg_wdata);
  end

  assign vec_suppress = (eff_len == LEN_RST);

  vmps_index_unit u_idx
  (
    .first      (first_r),
    .len        (len_r),
    .use_first  (opnd_select[4] && !opnd_is_mask),
    .scalar_idx (scalar_idx),
    .eff_len    (eff_len),
    .elem_idx   (elem_idx)
  );

  // Issue sequencer: serial mode holds issue until the previous instruction completes.
  always_ff @(posedge clk)
  begin
    if (srst)
      busy_r <= 1'b0;
    else if (advance)
      busy_r <= 1'b1;
    else if (instr_done)
      busy_r <= 1'b0;
  end

  assign serial_mode = processor_status_word[B_SERIAL];
  assign issue_ok    = !trace_pend_r && !(processor_status_word[B_SERIAL] && busy_r);
  assign advance     = issue_req && issue_ok;

  // Trace pending after each completed instruction until the handler is entered.
  always_ff @(posedge clk)
  begin
    if (srst)
      trace_pend_r <= 1'b0;
    else if (instr_done && processor_status_word[B_TRACE])
      trace_pend_r <= 1'b1;
    else if (trap_ack)
      trace_pend_r <= 1'b0;
  end

  assign trace_trap = trace_pend_r;

  // Sequencer state shown to software for debug.
  always_ff @(posedge clk)
  begin
    if (srst)
      state_r <= ST_IDLE;
    else
    begin
      unique case (state_r)
        ST_IDLE: if (trace_pend_r) state_r <= ST_TRAP; else if (advance) state_r <= ST_BUSY;
        ST_BUSY: if (trace_pend_r) state_r <= ST_TRAP; else if (instr_done && !advance) state_r <= ST_IDLE;
        ST_TRAP: if (trap_ack) state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Next program counter: segment-limited increment by two, bit 0 forced low.
  always_comb
  begin
    pc_nxt = pc_r;
    if (pc_load)
      pc_nxt = {pc_value[31:1], 1'b0};
    else if (advance)
    begin
      if (pc_r[31])
        pc_nxt = {1'b1, pc_r[30:1] + 30'h00000001, 1'b0};
      else
        pc_nxt = {pc_r[31:29], pc_r[28:1] + 28'h0000001, 1'b0};
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      pc_r <= PC_RST;
    else
      pc_r <= pc_nxt;
  end

  assign fetch_addr = {pc_r[31:1], 1'b0};

  // Traps are level outputs tracking the enables and flags directly.
  assign int_trap    = processor_status_word[B_IVE] && (processor_status_word[B_SOVF] || processor_status_word[B_AOVF]);
  assign dz_trap     = processor_status_word[B_DZE] && (processor_status_word[B_SDZ] || processor_status_word[B_ADZ]);
  assign status_word = processor_status_word;

  // Read data stand in the cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_r <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        REG_PC:    rdata_r <= fetch_addr;
        REG_PSW:   rdata_r <= processor_status_word;
        REG_FIRST: rdata_r <= {25'h0000000, first_r};
        REG_LEN:   rdata_r <= {24'h000000, len_r};
        REG_MASK0: rdata_r <= mask_r[31:0];
        REG_MASK1: rdata_r <= mask_r[63:32];
        REG_MASK2: rdata_r <= mask_r[95:64];
        REG_MASK3: rdata_r <= mask_r[127:96];
        REG_STAT:  rdata_r <= {28'h0000000, busy_r, trace_pend_r, state_r};
        default:   rdata_r <= 32'h00000000;
      endcase
    end
    else
      rdata_r <= 32'h00000000;
  end

  assign reg_rdata = rdata_r;

endmodule : vmps_regs
`default_nettype wire

// [tb/vmps_regs_chk.sv]
// Concurrent checks on the ports of the mask, offset, counter and status block.
// Assumes it is bound to the top module and shares its single clock and reset.
`timescale 1ns/1ns
`default_nettype none
module vmps_regs_chk
  import vmps_pkg::*;
(
  input wire logic         clk,
  input wire logic         srst,
  input wire logic [3:0]   reg_addr,
  input wire logic         reg_wr,
  input wire logic         cmp_vld,
  input wire logic [127:0] cmp_result,
  input wire logic [127:0] elem_mask,
  input wire logic [7:0]   eff_len,
  input wire logic         vec_suppress,
  input wire logic         a_carry_vld,
  input wire logic         a_carry,
  input wire logic         a_ovf,
  input wire logic         frame_vld,
  input wire logic [1:0]   frame_kind,
  input wire logic         issue_req,
  input wire logic         issue_ok,
  input wire logic         instr_done,
  input wire logic         pc_load,
  input wire logic [31:0]  fetch_addr,
  input wire logic         int_trap,
  input wire logic         dz_trap,
  input wire logic         trace_trap,
  input wire logic [31:0]  status_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // An advance is split by the segment bit, since the two cases carry into different fields.
  sequence s_adv_hi;
    issue_req && issue_ok && !pc_load && fetch_addr[31];
  endsequence
  sequence s_adv_lo;
    issue_req && issue_ok && !pc_load && !fetch_addr[31];
  endsequence
  sequence s_done;
    status_word[27] && instr_done;
  endsequence

  a_mask_load: assert property (cmp_vld |=> elem_mask == $past(cmp_result))
    else $error("mask not loaded from compare");
  a_supp_len: assert property (vec_suppress == (eff_len == 8'h00))
    else $error("suppress disagrees with length");
  a_addr_carry: assert property (a_carry_vld |=> status_word[31] == $past(a_carry))
    else $error("address carry not captured");
  a_ovf_set: assert property (a_ovf |=> status_word[30])
    else $error("address overflow not set");
  a_ovf_sticky: assert property (status_word[30] && !(reg_wr && reg_addr == REG_PSW) |=> status_word[30])
    else $error("overflow flag lost");
  a_int_trap: assert property (int_trap == (status_word[28] && (status_word[22] || status_word[30])))
    else $error("integer trap wrong");
  a_dz_trap: assert property (dz_trap == (status_word[20] && (status_word[21] || status_word[29])))
    else $error("divide trap wrong");
  a_frame_kind: assert property (frame_vld |=> status_word[26:25] == $past(frame_kind))
    else $error("frame kind not recorded");
  a_fetch_even: assert property (fetch_addr[0] == 1'b0)
    else $error("fetch address odd");
  a_step_hi: assert property (s_adv_hi |=> fetch_addr[30:1] == $past(fetch_addr[30:1]) + 30'h1)
    else $error("wide step wrong");
  a_step_lo: assert property (s_adv_lo |=> fetch_addr[31:29] == $past(fetch_addr[31:29]) &&
                              fetch_addr[28:1] == $past(fetch_addr[28:1]) + 28'h1)
    else $error("segment step wrong");
  a_trace_set: assert property (s_done |=> trace_trap && !issue_ok)
    else $error("trace trap missing");
endmodule : vmps_regs_chk

bind vmps_regs vmps_regs_chk i_chk (.*);
`default_nettype wire

// [tb/vmps_regs_bench.sv]
// Self-checking bench for the mask, offset, counter and status block.
// Assumes the package and design are compiled first and the checker is bound.
`timescale 1ns/1ns
`default_nettype none
module vmps_regs_bench
  import vmps_pkg::*;
;
  logic         clk, srst, reg_wr, reg_rd, cmp_vld, len_load, opnd_is_mask, vec_suppress;
  logic         a_carry_vld, a_carry, a_ovf, a_dz, s_carry_vld, s_carry, s_ovf, s_dz, frame_vld;
  logic         issue_req, instr_done, trap_ack, pc_load, issue_ok, int_trap, dz_trap, trace_trap;
  logic         serial_mode;
  logic [1:0]   frame_kind;
  logic [3:0]   reg_addr;
  logic [4:0]   opnd_select;
  logic [6:0]   scalar_idx, elem_idx;
  logic [7:0]   eff_len;
  logic [31:0]  reg_wdata, reg_rdata, len_value, pc_value, fetch_addr, status_word;
  logic [127:0] cmp_result, elem_mask, pat;
  int           errors, n_tests;

  vmps_regs i_vmps_regs (.*);

  // Free-running 4 ns clock.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compares with case inequality so an unknown never passes.
  task chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task results;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // Register port master: one-cycle strobes, read data taken in the following cycle only.
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
  endtask : rd

  // Ends a one-cycle event and lets that edge's updates land before anything is sampled.
  task clr;
    @(posedge clk);
    {cmp_vld, len_load, a_carry_vld, a_ovf, a_dz, s_carry_vld, s_ovf, s_dz, frame_vld} <= '0;
    {issue_req, instr_done, trap_ack, pc_load} <= '0;
    #1;
  endtask : clr

  // Hang guard, well beyond the hundred or so cycles the sequence needs.
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    results;
  end

  // Main sequence.
  initial
  begin
    {reg_wr, reg_rd, cmp_vld, len_load, opnd_is_mask, a_carry_vld, a_carry, a_ovf, a_dz, s_carry_vld,
     s_carry, s_ovf, s_dz, frame_vld, issue_req, instr_done, trap_ack, pc_load, frame_kind, reg_addr,
     opnd_select, scalar_idx, reg_wdata, len_value, pc_value, cmp_result} = '0;
    errors = 0;
    n_tests = 0;
    srst = 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(REG_PSW, 32'h0);
    chk("supp", 1'b1, vec_suppress);
    wr(4'hf, 32'h1234);
    rd(4'hf, 32'h0);
    wr(REG_PC, 32'h100);
    rd(REG_PC, 32'h0);
    // Flag events, carries and software clearing of the sticky bits.
    @(posedge clk);
    {a_ovf, s_dz, a_carry_vld, a_carry} <= 4'hf;
    clr;
    chk("psw", 32'hc0200000, status_word);
    @(posedge clk);
    a_carry_vld <= 1'b1;
    a_carry <= 1'b0;
    clr;
    chk("psw", 32'h40200000, status_word);
    @(posedge clk);
    {s_ovf, a_dz, s_carry_vld, s_carry} <= 4'hf;
    clr;
    chk("psw", 32'h60e00000, status_word);
    chk("traps", 2'b00, {int_trap, dz_trap});
    wr(REG_PSW, 32'h70f00000);
    chk("traps", 2'b11, {int_trap, dz_trap});
    rd(REG_PSW, 32'h70f00000);
    wr(REG_PSW, 32'hffffffff);
    rd(REG_PSW, 32'hfff00000);
    wr(REG_PSW, 32'h0);
    rd(REG_PSW, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      frame_vld <= 1'b1;
      frame_kind <= k[1:0];
      clr;
      chk("frame", k[1:0], status_word[26:25]);
    end
    // Compare results fill the mask, then their inverse clears every set element.
    pat = {32'h89abcdef, 32'h01234567, 32'hfedcba98, 32'h76543210};
    @(posedge clk);
    cmp_vld <= 1'b1;
    cmp_result <= pat;
    clr;
    chk("mask", pat, elem_mask);
    for (int k = 0; k < 4; k++)
      rd(REG_MASK0 + 4'(k), pat[32*k +: 32]);
    @(posedge clk);
    cmp_vld <= 1'b1;
    cmp_result <= ~pat;
    clr;
    chk("mask", ~pat, elem_mask);
    // Offset, clamped length and wrapped element index.
    wr(REG_FIRST, 32'hff);
    rd(REG_FIRST, 32'h7f);
    wr(REG_FIRST, 32'd100);
    @(posedge clk);
    len_load <= 1'b1;
    len_value <= 32'd200;
    opnd_select <= 5'h10;
    scalar_idx <= 7'd40;
    clr;
    chk("efflen", 8'd28, eff_len);
    chk("idx", 7'd12, elem_idx);
    @(posedge clk);
    opnd_is_mask <= 1'b1;
    clr;
    chk("efflen", 8'd128, eff_len);
    @(posedge clk);
    opnd_is_mask <= 1'b0;
    opnd_select <= 5'h0f;
    clr;
    chk("efflen", 8'd128, eff_len);
    rd(REG_LEN, 32'd128);
    @(posedge clk);
    len_load <= 1'b1;
    len_value <= 32'hffffff00;
    clr;
    chk("supp", 1'b1, vec_suppress);
    rd(REG_LEN, 32'h0);
    // Counter steps at both segment boundaries.
    @(posedge clk);
    pc_load <= 1'b1;
    pc_value <= 32'h8ffffffe;
    clr;
    @(posedge clk);
    issue_req <= 1'b1;
    clr;
    chk("fetch", 32'h90000000, fetch_addr);
    @(posedge clk);
    pc_load <= 1'b1;
    pc_value <= 32'h3fffffff;
    clr;
    chk("fetch", 32'h3ffffffe, fetch_addr);
    @(posedge clk);
    issue_req <= 1'b1;
    clr;
    chk("fetch", 32'h20000000, fetch_addr);
    // Serial mode holds the second request until completion; trace then blocks until acknowledged.
    // The earlier steps left an instruction outstanding, so complete it before serial mode starts.
    @(posedge clk);
    instr_done <= 1'b1;
    clr;
    wr(REG_PSW, 32'h09000000);
    chk("serial", 1'b1, serial_mode);
    @(posedge clk);
    issue_req <= 1'b1;
    @(posedge clk);
    clr;
    chk("fetch", 32'h20000002, fetch_addr);
    chk("issue", 1'b0, issue_ok);
    @(posedge clk);
    instr_done <= 1'b1;
    clr;
    chk("trace", 2'b10, {trace_trap, issue_ok});
    @(posedge clk);
    trap_ack <= 1'b1;
    clr;
    chk("trace", 2'b01, {trace_trap, issue_ok});
    results;
  end
endmodule : vmps_regs_bench
`default_nettype wire
